// ===== hw/spc_pkg.sv
// Shared constants for the speed command profiler
package spc_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS = 1000;

  // ------------------------------------------------------------
  // Widths and limits
  // ------------------------------------------------------------
  localparam int SPD_W = 16;
  localparam int TIME_W = 14;
  localparam int SIG_W = 10;
  localparam int SPEED_MIN = -20000;
  localparam int SPEED_MAX = 20000;
  localparam int ACC_MAX = 10000;
  localparam int SIG_MAX = 1000;
  localparam int ZLVL_MIN = 10;
  localparam int ZLVL_MAX = 20000;
  localparam int ZSEL_MAX = 3;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_SP0 = 8'h00;
  localparam logic [7:0] ADDR_SP_LAST = 8'h1C;
  localparam logic [7:0] ADDR_ACC = 8'h20;
  localparam logic [7:0] ADDR_DEC = 8'h24;
  localparam logic [7:0] ADDR_SIG = 8'h28;
  localparam logic [7:0] ADDR_ZSEL = 8'h2C;
  localparam logic [7:0] ADDR_ZLVL = 8'h30;
  localparam logic [7:0] ADDR_CTRL = 8'h34;
  localparam logic [7:0] ADDR_CMD = 8'h38;
  localparam logic [7:0] ADDR_STAT = 8'h3C;

  // ------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_POL_BIT = 4;
  localparam int STAT_CLAMP_BIT = 0;
  localparam int STAT_HOLD_BIT = 1;
  localparam int STAT_RAMP_BIT = 2;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [TIME_W-1:0] ACC_RST = 14'h0000;
  localparam logic [SIG_W-1:0] SIG_RST = 10'h000;
  localparam logic [1:0] ZSEL_IGNORE = 2'h0;
  localparam logic [1:0] ZSEL_FORCE = 2'h1;
  localparam logic [1:0] ZSEL_HOLD = 2'h2;
  localparam logic [14:0] ZLVL_RST = 15'h001E;
  localparam logic [2:0] SEL_RST = 3'h0;
  localparam logic POL_RST = 1'b0;

endpackage

// ===== hw/spc_tick.sv
// Enable-driven period counter that pulses once per period
`timescale 1ns/1ps
`default_nettype none
module spc_tick
  import spc_pkg::*;
#(
  parameter int PERIOD = 50,
  parameter int CW = 16
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  output logic tick
);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;

  // ------------------------------------------------------------
  // Count enables, wrap at end of period
  // ------------------------------------------------------------
  always_comb
  begin
    tick = en && (cnt_r == CW'(PERIOD - 1));
    cnt_nxt = cnt_r;
    if (tick)
      cnt_nxt = '0;
    else if (en)
      cnt_nxt = cnt_r + 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

endmodule
`default_nettype wire

// ===== hw/spc_div.sv
// Serial restoring divider for the rounding average
`timescale 1ns/1ps
`default_nettype none
module spc_div
  import spc_pkg::*;
#(
  parameter int DW = 26,
  parameter int VW = 11
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [DW-1:0] dividend,
  input wire logic [VW-1:0] divisor,
  output logic [DW-1:0] quotient,
  output logic done
);

  logic [DW-1:0] quo_r, quo_nxt;
  logic [VW:0] rem_r, rem_nxt;
  logic [VW-1:0] dvs_r, dvs_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic [VW:0] trial;

  // ------------------------------------------------------------
  // One quotient bit per cycle, MSB first
  // ------------------------------------------------------------
  always_comb
  begin
    quo_nxt = quo_r;
    rem_nxt = rem_r;
    dvs_nxt = dvs_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    trial = {rem_r[VW-1:0], quo_r[DW-1]};
    if (start)
    begin
      quo_nxt = dividend;
      rem_nxt = '0;
      dvs_nxt = divisor;
      cnt_nxt = 6'(DW);
      busy_nxt = 1'b1;
    end
    else if (busy_r)
    begin
      if (trial >= {1'b0, dvs_r})
      begin
        rem_nxt = trial - {1'b0, dvs_r};
        quo_nxt = {quo_r[DW-2:0], 1'b1};
      end
      else
      begin
        rem_nxt = trial;
        quo_nxt = {quo_r[DW-2:0], 1'b0};
      end
      cnt_nxt = cnt_r - 1'b1;
      if (cnt_r == 6'h01)
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      quo_r <= '0;
      rem_r <= '0;
      dvs_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      quo_r <= quo_nxt;
      rem_r <= rem_nxt;
      dvs_r <= dvs_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign quotient = quo_r;
  assign done = done_r;

endmodule
`default_nettype wire

// ===== hw/spc_profiler.sv
// Speed command profiler: setpoints, ramps, S-curve rounding, zero clamp
//
// Function
// R1 - Eight signed setpoints from -20000 to 20000 r/min, reset to 0, give the target speed.
// R2 - The acceleration setting, 0 to 10000 ms per 1000 r/min, reset 0, sets the rise rate.
// R3 - The deceleration setting, 0 to 10000 ms per 1000 r/min, reset 0, sets the fall rate.
// R4 - Rising to a target takes target/1000 times the acceleration setting in ms.
// R5 - Falling from a target takes target/1000 times the deceleration setting in ms.
// R6 - S-curve rounding of width sigmoid setting in ms, 0 to 1000, is centred on each corner; the code rounds from each corner to width ms after it.
// R7 - Software should keep the S-curve width under half of each ramp duration.
// R8 - Zero-clamp select runs 0 to 3, reset 0, and with 0 the clamp input is ignored.
// R9 - With select 1 the speed command is forced to zero while the clamp input is active.
// R10 - With select 2 the clamp also switches to position hold once actual speed is at or below the level.
// R11 - The clamp input is active low by default, so an open terminal asserts the clamp.
// R12 - The clamp level runs 10 to 20000 r/min, reset 30, as the position hold threshold.
// R13 - Select 3 behaves as select 0.
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spc_profiler
  import spc_pkg::*;
#(
  parameter int FLT_AW = 10
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic zero_clamp_input,
  input wire logic signed [SPD_W-1:0] actual_speed,
  output logic signed [SPD_W-1:0] speed_cmd,
  output logic clamp_active,
  output logic pos_hold
);

  localparam int FLT_DEPTH = 1 << FLT_AW;
  localparam int SUM_W = SPD_W + SIG_W + 1;

  // ------------------------------------------------------------
  // Saturation helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] sat_s(input logic [15:0] v, input int lo, input int hi);
    int x;
    x = int'($signed(v));
    if (x < lo)
      x = lo;
    if (x > hi)
      x = hi;
    return 16'(x);
  endfunction

  function automatic logic [15:0] sat_u(input logic [15:0] v, input int lo, input int hi);
    int x;
    x = int'(v);
    if (x < lo)
      x = lo;
    if (x > hi)
      x = hi;
    return 16'(x);
  endfunction

  // ------------------------------------------------------------
  // State declarations
  // ------------------------------------------------------------
  logic [15:0] sp_r [0:7];
  logic [15:0] sp_nxt [0:7];
  logic [TIME_W-1:0] acc_r, acc_nxt, dec_r, dec_nxt;
  logic [SIG_W-1:0] sig_r, sig_nxt;
  logic [1:0] zsel_r, zsel_nxt;
  logic [14:0] zlvl_r, zlvl_nxt;
  logic [2:0] sel_r, sel_nxt;
  logic pol_r, pol_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [31:0] rd_val;
  logic mapped;
  logic wr_en;
  logic sig_wr;
  logic [15:0] wv;
  logic us_tick, ms_tick;
  logic signed [SPD_W-1:0] lin_r, lin_nxt, tgt;
  logic [TIME_W-1:0] step_r, step_nxt, rate;
  logic toward_zero;
  logic clamp_r, clamp_nxt, hold_r, hold_nxt, clamp_in;
  logic [SPD_W:0] act_mag;
  logic [SPD_W-1:0] fbuf [0:FLT_DEPTH-1];
  logic signed [SUM_W-1:0] sum_r, sum_nxt;
  logic [FLT_AW-1:0] wr_r, wr_nxt;
  logic [SIG_W:0] fill_r, fill_nxt;
  logic signed [SPD_W-1:0] flush_r, flush_nxt, old_val;
  logic signed [SPD_W-1:0] filt_r, filt_nxt;
  logic neg_r, neg_nxt;
  logic div_start_r, div_start_nxt;
  logic [SUM_W-2:0] div_mag;
  logic [SUM_W-2:0] div_quo;
  logic div_done;
  logic signed [SPD_W-1:0] cmd_r, cmd_nxt;

  // ------------------------------------------------------------
  // Time bases: 1 us and 1 ms
  // ------------------------------------------------------------
  spc_tick #(.PERIOD(CYC_PER_US), .CW(8)) u_us_tick (
    .pclk(pclk),
    .presetn(presetn),
    .en(1'b1),
    .tick(us_tick)
  );

  spc_tick #(.PERIOD(US_PER_MS), .CW(10)) u_ms_tick (
    .pclk(pclk),
    .presetn(presetn),
    .en(us_tick),
    .tick(ms_tick)
  );

  // ------------------------------------------------------------
  // APB decode and read mux
  // ------------------------------------------------------------
  always_comb
  begin
    rd_val = '0;
    mapped = 1'b1;
    case (paddr)
      ADDR_ACC: rd_val[TIME_W-1:0] = acc_r;
      ADDR_DEC: rd_val[TIME_W-1:0] = dec_r;
      ADDR_SIG: rd_val[SIG_W-1:0] = sig_r;
      ADDR_ZSEL: rd_val[1:0] = zsel_r;
      ADDR_ZLVL: rd_val[14:0] = zlvl_r;
      ADDR_CTRL:
      begin
        rd_val[CTRL_SEL_LSB +: 3] = sel_r;
        rd_val[CTRL_POL_BIT] = pol_r;
      end
      ADDR_CMD: rd_val[SPD_W-1:0] = cmd_r;
      ADDR_STAT:
      begin
        rd_val[STAT_CLAMP_BIT] = clamp_r;
        rd_val[STAT_HOLD_BIT] = hold_r;
        rd_val[STAT_RAMP_BIT] = (lin_r != tgt);
      end
      default:
      begin
        if (paddr <= ADDR_SP_LAST && paddr[1:0] == 2'h0)
          rd_val[15:0] = sp_r[paddr[4:2]]; // R1
        else
          mapped = 1'b0;
      end
    endcase
  end

  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;
  assign wr_en = psel && penable && pwrite && mapped;
  assign sig_wr = wr_en && (paddr == ADDR_SIG);
  assign wv = {pstrb[1] ? pwdata[15:8] : rd_val[15:8], pstrb[0] ? pwdata[7:0] : rd_val[7:0]};

  // ------------------------------------------------------------
  // Register file writes, saturated to legal ranges
  // ------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      sp_nxt[i] = sp_r[i];
    acc_nxt = acc_r;
    dec_nxt = dec_r;
    sig_nxt = sig_r;
    zsel_nxt = zsel_r;
    zlvl_nxt = zlvl_r;
    sel_nxt = sel_r;
    pol_nxt = pol_r;
    prdata_nxt = (psel && !penable) ? rd_val : prdata_r;
    if (wr_en)
    begin
      case (paddr)
        ADDR_ACC: acc_nxt = TIME_W'(sat_u(wv, 0, ACC_MAX)); // R2
        ADDR_DEC: dec_nxt = TIME_W'(sat_u(wv, 0, ACC_MAX)); // R3
        ADDR_SIG: sig_nxt = SIG_W'(sat_u(wv, 0, SIG_MAX)); // R6
        ADDR_ZSEL: zsel_nxt = 2'(sat_u(wv, 0, ZSEL_MAX)); // R8
        ADDR_ZLVL: zlvl_nxt = 15'(sat_u(wv, ZLVL_MIN, ZLVL_MAX)); // R12
        ADDR_CTRL:
        begin
          sel_nxt = wv[CTRL_SEL_LSB +: 3];
          pol_nxt = wv[CTRL_POL_BIT];
        end
        default:
        begin
          if (paddr <= ADDR_SP_LAST)
            sp_nxt[paddr[4:2]] = sat_s(wv, SPEED_MIN, SPEED_MAX); // R1
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
        sp_r[i] <= SP_RST; // R1
      acc_r <= ACC_RST; // R2
      dec_r <= ACC_RST; // R3
      sig_r <= SIG_RST;
      zsel_r <= ZSEL_IGNORE; // R8
      zlvl_r <= ZLVL_RST; // R12
      sel_r <= SEL_RST;
      pol_r <= POL_RST; // R11
      prdata_r <= '0;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
        sp_r[i] <= sp_nxt[i];
      acc_r <= acc_nxt;
      dec_r <= dec_nxt;
      sig_r <= sig_nxt;
      zsel_r <= zsel_nxt;
      zlvl_r <= zlvl_nxt;
      sel_r <= sel_nxt;
      pol_r <= pol_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;

  // ------------------------------------------------------------
  // Zero clamp and position hold
  // ------------------------------------------------------------
  always_comb
  begin
    clamp_in = (zero_clamp_input == pol_r); // R11
    act_mag = actual_speed[SPD_W-1] ? (SPD_W+1)'(-$signed({actual_speed[SPD_W-1], actual_speed}))
                                    : {1'b0, actual_speed};
    clamp_nxt = clamp_in && (zsel_r == ZSEL_FORCE || zsel_r == ZSEL_HOLD); // R8 R9 R13
    hold_nxt = clamp_nxt && (zsel_r == ZSEL_HOLD)
               && (hold_r || act_mag <= (SPD_W+1)'(zlvl_r)); // R10
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clamp_r <= 1'b0;
      hold_r <= 1'b0;
    end
    else
    begin
      clamp_r <= clamp_nxt;
      hold_r <= hold_nxt;
    end
  end

  assign clamp_active = clamp_r;
  assign pos_hold = hold_r;

  // ------------------------------------------------------------
  // Linear ramp: 1 r/min per setting microseconds
  // ------------------------------------------------------------
  always_comb
  begin
    tgt = clamp_r ? '0 : $signed(sp_r[sel_r]); // R9
    toward_zero = (lin_r > 0 && tgt < lin_r) || (lin_r < 0 && tgt > lin_r);
    rate = toward_zero ? dec_r : acc_r; // R4 R5
    lin_nxt = lin_r;
    step_nxt = step_r;
    if (lin_r == tgt || rate == '0)
    begin
      lin_nxt = tgt; // Zero setting steps at once
      step_nxt = '0;
    end
    else if (us_tick)
    begin
      if (step_r + 1'b1 >= rate)
      begin
        step_nxt = '0;
        lin_nxt = (tgt > lin_r) ? lin_r + SPD_W'(1'b1) : lin_r - SPD_W'(1'b1); // R4 R5
      end
      else
        step_nxt = step_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lin_r <= '0;
      step_r <= '0;
    end
    else
    begin
      lin_r <= lin_nxt;
      step_r <= step_nxt;
    end
  end

  // ------------------------------------------------------------
  // S-curve: moving average of the ramp over width ms
  // ------------------------------------------------------------
  always_comb
  begin
    old_val = (fill_r < {1'b0, sig_r}) ? flush_r : $signed(fbuf[wr_r - FLT_AW'(sig_r)]);
    sum_nxt = sum_r;
    wr_nxt = wr_r;
    fill_nxt = fill_r;
    flush_nxt = flush_r;
    neg_nxt = neg_r;
    div_start_nxt = 1'b0;
    filt_nxt = filt_r;
    if (sig_wr)
    begin
      sum_nxt = SUM_W'(lin_r * $signed({1'b0, sig_nxt})); // Refill window with current speed
      fill_nxt = '0;
      flush_nxt = lin_r;
    end
    else if (ms_tick && sig_r != '0)
    begin
      sum_nxt = sum_r + SUM_W'(lin_r) - SUM_W'(old_val); // R6
      wr_nxt = wr_r + 1'b1;
      if (fill_r < {1'b0, sig_r})
        fill_nxt = fill_r + 1'b1;
      neg_nxt = sum_nxt[SUM_W-1];
      div_start_nxt = 1'b1;
    end
    if (sig_wr)
      filt_nxt = lin_r; // Output starts from the refilled window, no jump
    else if (div_done)
      filt_nxt = neg_r ? -$signed(div_quo[SPD_W-1:0]) : $signed(div_quo[SPD_W-1:0]);
    div_mag = neg_r ? (SUM_W-1)'(-sum_r) : (SUM_W-1)'(sum_r);
    cmd_nxt = (sig_r == '0) ? lin_r : filt_r; // R6
  end

  always_ff @(posedge pclk)
  begin
    if (ms_tick && sig_r != '0 && !sig_wr)
      fbuf[wr_r] <= lin_r;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sum_r <= '0;
      wr_r <= '0;
      fill_r <= '0;
      flush_r <= '0;
      neg_r <= 1'b0;
      div_start_r <= 1'b0;
      filt_r <= '0;
      cmd_r <= '0;
    end
    else
    begin
      sum_r <= sum_nxt;
      wr_r <= wr_nxt;
      fill_r <= fill_nxt;
      flush_r <= flush_nxt;
      neg_r <= neg_nxt;
      div_start_r <= div_start_nxt;
      filt_r <= filt_nxt;
      cmd_r <= cmd_nxt;
    end
  end

  spc_div #(.DW(SUM_W-1), .VW(SIG_W)) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .start(div_start_r),
    .dividend(div_mag),
    .divisor(sig_r),
    .quotient(div_quo),
    .done(div_done)
  );

  assign speed_cmd = cmd_r;

endmodule
`default_nettype wire

// ===== dv/spc_profiler_props.sv
// Port-level checker for the speed command profiler
`timescale 1ns/1ps
`default_nettype none
module spc_profiler_props
  import spc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic signed [SPD_W-1:0] speed_cmd,
  input wire logic clamp_active,
  input wire logic pos_hold
);
  // ------------------------------------------------------------
  // Clocking and read setups
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence cmd_setup;
    psel && !penable && !pwrite && paddr == ADDR_CMD;
  endsequence
  sequence stat_setup;
    psel && !penable && !pwrite && paddr == ADDR_STAT;
  endsequence

  // ------------------------------------------------------------
  // Bus and output relations
  // ------------------------------------------------------------
  pready_match_a: assert property (pready == (psel && penable))
    else $error("pready does not follow the access phase");
  err_in_access_a: assert property (pslverr |-> pready)
    else $error("error response outside an access phase");
  err_zero_data_a: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data moved outside a setup cycle");
  cmd_read_a: assert property (cmd_setup ##1 pready |-> prdata == {16'h0000, $past(speed_cmd)})
    else $error("command read differs from the output");
  stat_read_a: assert property (stat_setup ##1 pready
    |-> prdata[1:0] == {$past(pos_hold), $past(clamp_active)})
    else $error("status read differs from the outputs");
  cmd_range_a: assert property (speed_cmd >= -20000 && speed_cmd <= 20000)
    else $error("speed command out of range");
  hold_start_a: assert property ($rose(pos_hold) |-> clamp_active)
    else $error("position hold began without a clamp");
  hold_release_a: assert property (!clamp_active [*2] |-> !pos_hold)
    else $error("position hold outlived the clamp");
endmodule
bind spc_profiler spc_profiler_props spc_profiler_props_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .speed_cmd(speed_cmd), .clamp_active(clamp_active),
  .pos_hold(pos_hold));
`default_nettype wire

// ===== dv/spc_host_model.sv
// Host-side model: clamp contact and a lagging speed loop
`timescale 1ns/1ps
`default_nettype none
module spc_host_model
  import spc_pkg::*;
#(
  parameter int STEP = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic contact_closed,
  input wire logic signed [SPD_W-1:0] speed_cmd,
  output logic zero_clamp_input,
  output logic signed [SPD_W-1:0] actual_speed
);
  // Open contact reads low
  assign zero_clamp_input = contact_closed;
  // Motor speed trails the command by STEP per cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      actual_speed <= '0;
    else if (actual_speed > speed_cmd + STEP)
      actual_speed <= SPD_W'(actual_speed - STEP);
    else if (actual_speed < speed_cmd - STEP)
      actual_speed <= SPD_W'(actual_speed + STEP);
    else
      actual_speed <= speed_cmd;
  end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Testbench for the speed command profiler
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import spc_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic zero_clamp_input, clamp_active, pos_hold, contact_closed;
  logic signed [SPD_W-1:0] actual_speed, speed_cmd;
  int err_total, cmp_count;

  // ------------------------------------------------------------
  // Design and far side
  // ------------------------------------------------------------
  spc_profiler spc_profiler_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .zero_clamp_input(zero_clamp_input),
    .actual_speed(actual_speed), .speed_cmd(speed_cmd), .clamp_active(clamp_active),
    .pos_hold(pos_hold));
  spc_host_model spc_host_model_i (.pclk(pclk), .presetn(presetn),
    .contact_closed(contact_closed), .speed_cmd(speed_cmd),
    .zero_clamp_input(zero_clamp_input), .actual_speed(actual_speed));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_of_test();
    if (err_total == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, waiting for pready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      err_total++;
      end_of_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask
  // Bounded wait for command, clamp and hold outputs
  task automatic wait_out(input logic [15:0] cmd, input logic cl, input logic ph, input int lim);
    int n;
    n = 0;
    while ({speed_cmd, clamp_active, pos_hold} !== {cmd, cl, ph} && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    chk({14'h0, speed_cmd, clamp_active, pos_hold}, {14'h0, cmd, cl, ph});
    if (n >= lim && lim > 1)
      end_of_test();
  endtask

  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial
  begin
    logic [31:0] q;
    logic e;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    contact_closed = 1'b1;
    err_total = 0;
    cmp_count = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 14; i++)
      rd(8'(i * 4), (i == 12) ? 32'h0000_001E : 32'h0);
    apb(1'b0, 8'h40, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    wr(ADDR_SP0, 32'h0000_7530);
    rd(ADDR_SP0, 32'h0000_4E20);
    wr(ADDR_SP0, 32'hFFFF_8AD0);
    rd(ADDR_SP0, 32'h0000_B1E0);
    wr(ADDR_ZLVL, 32'h5);
    rd(ADDR_ZLVL, 32'hA);
    wr(ADDR_ZLVL, 32'h1E);
    wr(ADDR_CMD, 32'h1234);
    wr(8'h04, 32'h1F4);
    wr(ADDR_CTRL, 32'h1);
    wait_out(16'h01F4, 1'b0, 1'b0, 50);
    rd(ADDR_CMD, 32'h0000_01F4);
    // Rise of 40 r/min at one per us, midpoint then end
    wr(ADDR_ACC, 32'h1);
    wr(8'h04, 32'h21C);
    repeat (1000) @(posedge pclk);
    chk({31'h0, speed_cmd > 16'sd517 && speed_cmd < 16'sd523}, 32'h1);
    rd(ADDR_STAT, 32'h4);
    wait_out(16'h021C, 1'b0, 1'b0, 1500);
    // Fall of 40 r/min at one per 2 us
    wr(ADDR_DEC, 32'h2);
    wr(8'h04, 32'h1F4);
    repeat (2000) @(posedge pclk);
    chk({31'h0, speed_cmd > 16'sd517 && speed_cmd < 16'sd523}, 32'h1);
    wait_out(16'h01F4, 1'b0, 1'b0, 2500);
    // Rounding of 1 ms against a ramp of 0.4 ms holds the command near 500
    wr(ADDR_ACC, 32'h4);
    wr(ADDR_DEC, 32'h4);
    wr(ADDR_SIG, 32'h1);
    wr(8'h04, 32'h258);
    repeat (200) @(posedge pclk);
    chk({31'h0, speed_cmd >= 16'sh01F4 && speed_cmd < 16'sh0258}, 32'h1);
    wr(ADDR_SIG, 32'h0);
    wr(ADDR_ACC, 32'h0);
    wr(ADDR_DEC, 32'h0);
    wait_out(16'h0258, 1'b0, 1'b0, 100);
    rd(ADDR_CMD, 32'h0000_0258);
    // Clamp selections with the contact open
    contact_closed <= 1'b0;
    repeat (20) @(posedge pclk);
    wait_out(16'h0258, 1'b0, 1'b0, 1);
    wr(ADDR_ZSEL, 32'h3);
    repeat (20) @(posedge pclk);
    wait_out(16'h0258, 1'b0, 1'b0, 1);
    wr(ADDR_ZSEL, 32'h1);
    wait_out(16'h0000, 1'b1, 1'b0, 20);
    contact_closed <= 1'b1;
    wait_out(16'h0258, 1'b0, 1'b0, 20);
    wr(ADDR_ZSEL, 32'h2);
    contact_closed <= 1'b0;
    wait_out(16'h0000, 1'b1, 1'b1, 400);
    rd(ADDR_STAT, 32'h3);
    wr(ADDR_CTRL, 32'h11);
    wait_out(16'h0258, 1'b0, 1'b0, 400);
    end_of_test();
  end
endmodule
`default_nettype wire
